// >>> hw/timer_event_counters_pkg.sv
// Constants for the three timer/event counters
package timer_event_counters_pkg;
  localparam int ADDR_W = 4;
  // Register indices on the special-function bus
  localparam logic [3:0] ADDR_C0_LOW = 4'h0;
  localparam logic [3:0] ADDR_C0_HIGH = 4'h1;
  localparam logic [3:0] ADDR_C0_CTRL = 4'h2;
  localparam logic [3:0] ADDR_C1_LOW = 4'h3;
  localparam logic [3:0] ADDR_C1_HIGH = 4'h4;
  localparam logic [3:0] ADDR_C1_CTRL = 4'h5;
  localparam logic [3:0] ADDR_C2_VALUE = 4'h6;
  localparam logic [3:0] ADDR_C2_CTRL = 4'h7;
  localparam logic [3:0] ADDR_INT_CTRL = 4'h8;
  // Control register fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RUN_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int PRESC_HI = 2;
  localparam int PRESC_LO = 0;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_CTRL_RESET = 8'h00;
  localparam logic [7:0] RUN_CLEAR_MASK = 8'hef;
  localparam logic [7:0] IE_MASK = 8'h07;
  // Prescaler divider width: ratios up to 2^7
  localparam int PRESC_W = 7;
endpackage

// >>> hw/timer_event_counters.sv
// Three count-up timer/event counters with preload, prescaler and byte buffering
//
// Functional notes
// [R1] Counters 0,1 are 16-bit byte pairs; counter 2 is one 8-bit register.
// [R2] Control bits 7:6 select timer, event or pulse width mode.
// [R3] Mode 10 selects timer mode.
// [R4] Control bit 4 runs the counter; clearing it stops it.
// [R5] Counters 0,2 prescale by bits 2:0; ignored with external clock.
// [R6] Bit 3 picks active pin polarity in event and pulse modes.
// [R7] System clock in timer and pulse modes; pin in event mode.
// [R8] Event mode adds exactly one per active pin transition.
// [R9] Count to all ones, overflow raises request, reloads preload, continues.
// [R10] Preload write when stopped loads counter too; when running, next overflow.
// [R11] Preload is not reset; software clears it for full range.
// [R12] 16-bit low byte write goes only to a holding buffer.
// [R13] High byte write loads high byte and copies buffer into low.
// [R14] Software writes low byte before high byte.
// [R15] High byte read latches live low byte into the buffer.
// [R16] Low byte read returns the latched buffer.
// [R17] Timer mode counts per internal clock (system clock or divided).
// [R18] Overflow request is gated by its enable bit in interrupt control.
// [R19] Mode 01 selects event counting; prescaler bypassed.
// [R20] Edge select low counts rising, high counts falling. In pulse mode the code inverts this: low arms on falling, high on rising.
// [R21] Mode 11 counts while pin active after edge; return clears run bit.
// [R22] Prescaler field n divides by two to the power n.
// [R23] Each overflow is a one-cycle pulse setting its request flag.
`timescale 1ns/1ps
module timer_event_counters (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register access from the core
  input wire logic [3:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  // External timer pins
  input wire logic [2:0] timer_pin_i,
  // Interrupt request flags, cleared by software acknowledge
  input wire logic [2:0] irq_clear_i,
  output logic [2:0] irq_flag_o,
  output logic [2:0] irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [3:0] ctrl_addr(input int idx);
    if (idx == 0) begin
      ctrl_addr = timer_event_counters_pkg::ADDR_C0_CTRL;
    end else if (idx == 1) begin
      ctrl_addr = timer_event_counters_pkg::ADDR_C1_CTRL;
    end else begin
      ctrl_addr = timer_event_counters_pkg::ADDR_C2_CTRL;
    end
  endfunction

  // Address of the byte that carries preload data, straight to the counter only while it is stopped
  function automatic logic [3:0] load_addr(input int idx);
    if (idx == 0) begin
      load_addr = timer_event_counters_pkg::ADDR_C0_HIGH;
    end else if (idx == 1) begin
      load_addr = timer_event_counters_pkg::ADDR_C1_HIGH;
    end else begin
      load_addr = timer_event_counters_pkg::ADDR_C2_VALUE;
    end
  endfunction

  function automatic logic [3:0] low_addr(input int idx);
    if (idx == 0) begin
      low_addr = timer_event_counters_pkg::ADDR_C0_LOW;
    end else begin
      low_addr = timer_event_counters_pkg::ADDR_C1_LOW;
    end
  endfunction

  // Pulse mode decode, shared by the pin polarity and the arming logic
  function automatic logic pulse_mode(input logic [1:0] m);
    pulse_mode = (m == timer_event_counters_pkg::MODE_PULSE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Shared state

  logic [7:0] int_ctrl_reg;
  logic [2:0] irq_flag_reg;
  logic [2:0] ovf_pulse;
  logic [7:0] ctrl_state [3];
  logic [15:0] count_state [3];
  logic [7:0] low_buf_state [2];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_ctrl_reg <= timer_event_counters_pkg::INT_CTRL_RESET;
    end else if (wr_en_i && addr_i == timer_event_counters_pkg::ADDR_INT_CTRL) begin
      int_ctrl_reg <= wr_data_i & timer_event_counters_pkg::IE_MASK;
    end
  end

  // [R23] Overflow sets flag
  // Set wins over a clear in the same cycle so no overflow is lost
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flag_reg <= 3'h0;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~irq_clear_i) | ovf_pulse;
    end
  end

  assign irq_flag_o = irq_flag_reg;
  // [R18] Enable gates request
  assign irq_o = irq_flag_reg & int_ctrl_reg[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter logic

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cnt
      // [R1] Width per counter
      localparam int WIDTH = (g == 2) ? 8 : 16;
      localparam bit HAS_PRESC = (g != 1);
      localparam logic [WIDTH-1:0] ALL_ONES = '1;

      logic [7:0] ctrl_reg;
      logic [WIDTH-1:0] count_reg;
      // [R11] Preload has no reset value
      logic [WIDTH-1:0] preload_reg;
      logic [WIDTH-1:0] load_value;
      localparam int PRESC_W_L = timer_event_counters_pkg::PRESC_W;
      logic [PRESC_W_L-1:0] presc_reg;
      logic pin_d_reg;
      logic armed_reg;
      logic [1:0] mode;
      logic running;
      logic edge_sel;
      logic level_inv;
      logic pin_active;
      logic active_edge;
      logic release_edge;
      logic tick_int;
      logic tick;
      logic overflow;
      logic ctrl_wr;
      logic load_wr;
      logic auto_stop;

      // [R2] Mode field
      assign mode = ctrl_reg[timer_event_counters_pkg::MODE_HI:
                             timer_event_counters_pkg::MODE_LO];
      // [R4] Run control
      assign running = ctrl_reg[timer_event_counters_pkg::RUN_BIT];
      // [R6] Edge polarity
      assign edge_sel = ctrl_reg[timer_event_counters_pkg::EDGE_BIT];
      assign ctrl_wr = wr_en_i && addr_i == ctrl_addr(g);
      assign load_wr = wr_en_i && addr_i == load_addr(g);

      // [R20] Low selects rising
      // Pulse mode arms on the opposite edge, so its polarity is inverted
      assign level_inv = edge_sel ^ pulse_mode(mode);
      assign pin_active = timer_pin_i[g] ^ level_inv;
      assign active_edge = pin_active && !(pin_d_reg ^ level_inv);
      // Pulse mode: active level is the one entered by the edge opposite to the one bit 3 selects
      assign release_edge = !pin_active && (pin_d_reg ^ level_inv);

      // One sample of history: edges take effect a cycle after the pin moves
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_d_reg <= 1'b0;
        end else begin
          pin_d_reg <= timer_pin_i[g];
        end
      end

      // [R22] Divide by 2^n
      if (HAS_PRESC) begin : g_presc
        logic [PRESC_W_L-1:0] presc_mask;
        assign presc_mask = PRESC_W_L'((8'h01 << ctrl_reg[
          timer_event_counters_pkg::PRESC_HI:timer_event_counters_pkg::PRESC_LO]) - 8'h01);
        // Restarts from zero when stopped so the first period after a start is full
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
          if (!rst_n_i) begin
            presc_reg <= '0;
          end else if (!running) begin
            presc_reg <= '0;
          end else begin
            presc_reg <= presc_reg + PRESC_W_L'(1);
          end
        end
        // [R5] Prescaled internal clock
        assign tick_int = (presc_reg & presc_mask) == presc_mask;
      end else begin : g_nopresc
        assign presc_reg = '0;
        // [R17] One count per cycle
        assign tick_int = 1'b1;
      end

      // [R7] Clock source by mode
      always_comb begin
        tick = 1'b0;
        auto_stop = 1'b0;
        if (running) begin
          case (mode)
            // [R3] Timer mode
            timer_event_counters_pkg::MODE_TIMER: tick = tick_int;
            // [R19] [R8] Event mode, prescaler bypassed
            timer_event_counters_pkg::MODE_EVENT: tick = active_edge;
            // [R21] Count while armed and active
            timer_event_counters_pkg::MODE_PULSE: begin
              tick = armed_reg && pin_active && tick_int;
              auto_stop = armed_reg && release_edge;
            end
            // Mode 00 holds the count
            default: tick = 1'b0;
          endcase
        end
      end

      // Armed marks a pulse in progress; a stop drops it so a restart waits for an edge
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          armed_reg <= 1'b0;
        end else if (!running || auto_stop) begin
          armed_reg <= 1'b0;
        end else if (pulse_mode(mode) && active_edge) begin
          armed_reg <= 1'b1;
        end
      end

      // A software write wins over a hardware stop in the same cycle
      // [R21] Auto clear of run bit
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ctrl_reg <= timer_event_counters_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
          ctrl_reg <= wr_data_i;
        end else if (auto_stop) begin
          ctrl_reg <= ctrl_reg & timer_event_counters_pkg::RUN_CLEAR_MASK;
        end
      end

      // The reload takes the place of the increment on the overflowing tick
      // [R9] Overflow at all ones
      assign overflow = tick && count_reg == ALL_ONES;
      assign ovf_pulse[g] = overflow;

      // [R13] High write pairs with buffered low
      if (WIDTH == 16) begin : g_wide
        assign load_value = {wr_data_i, low_buf_state[g]};
      end else begin : g_narrow
        assign load_value = wr_data_i;
      end

      // No reset on purpose: software must load it before the first overflow
      always_ff @(posedge clk_sys_i) begin
        if (load_wr) begin
          preload_reg <= load_value;
        end
      end

      // [R10] Direct load only when stopped
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          count_reg <= '0;
        end else if (load_wr && !running) begin
          count_reg <= load_value;
        end else if (overflow) begin
          count_reg <= preload_reg;
        end else if (tick) begin
          count_reg <= count_reg + WIDTH'(1);
        end
      end

      assign ctrl_state[g] = ctrl_reg;
      // Narrow counter widened so the read mux sees one shape
      assign count_state[g] = 16'(count_reg);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Low byte buffers of the 16-bit counters

  generate
    for (g = 0; g < 2; g++) begin : g_buf
      logic [7:0] low_buf_reg;
      // One access per cycle, so a low write never meets a latching read
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          low_buf_reg <= 8'h00;
        end else if (wr_en_i && addr_i == low_addr(g)) begin
          // [R12] Low write buffered only
          low_buf_reg <= wr_data_i;
        end else if (rd_en_i && addr_i == load_addr(g)) begin
          // [R15] High read latches low
          low_buf_reg <= count_state[g][7:0];
        end
      end
      assign low_buf_state[g] = low_buf_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered

  logic [7:0] rd_next;

  always_comb begin
    if (addr_i == timer_event_counters_pkg::ADDR_C0_LOW) begin
      // [R16] Low read returns buffer
      rd_next = low_buf_state[0];
    end else if (addr_i == timer_event_counters_pkg::ADDR_C0_HIGH) begin
      rd_next = count_state[0][15:8];
    end else if (addr_i == timer_event_counters_pkg::ADDR_C0_CTRL) begin
      rd_next = ctrl_state[0];
    end else if (addr_i == timer_event_counters_pkg::ADDR_C1_LOW) begin
      rd_next = low_buf_state[1];
    end else if (addr_i == timer_event_counters_pkg::ADDR_C1_HIGH) begin
      rd_next = count_state[1][15:8];
    end else if (addr_i == timer_event_counters_pkg::ADDR_C1_CTRL) begin
      rd_next = ctrl_state[1];
    end else if (addr_i == timer_event_counters_pkg::ADDR_C2_VALUE) begin
      rd_next = count_state[2][7:0];
    end else if (addr_i == timer_event_counters_pkg::ADDR_C2_CTRL) begin
      rd_next = ctrl_state[2];
    end else if (addr_i == timer_event_counters_pkg::ADDR_INT_CTRL) begin
      rd_next = int_ctrl_reg;
    end else begin
      rd_next = 8'h00;
    end
  end

  // Registered so an answer holds until the next read strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      rd_data_o <= rd_next;
    end
  end

endmodule

// >>> tb/pulse_source.sv
// Behavioural pulse source standing on the external timer pins
`timescale 1ns/1ps
module pulse_source (
  // Clock and command from the bench
  input wire logic clk_sys_i,
  input wire logic start_i,
  input wire logic idle_i,
  input wire logic [7:0] width_i,
  input wire logic [3:0] count_i,
  // Pin and status
  output logic pin_o,
  output logic busy_o
);
  logic drv = 1'b0;
  // Idle level follows the command at once so a level change never looks like a pulse
  assign pin_o = busy_o ? drv : idle_i;
  initial busy_o = 1'b0;
  always begin
    @(posedge clk_sys_i iff start_i);
    #1 busy_o = 1'b1;
    repeat (count_i) begin
      drv = ~idle_i;
      repeat (width_i) @(posedge clk_sys_i);
      #1 drv = idle_i;
      repeat (width_i) @(posedge clk_sys_i);
      #1;
    end
    busy_o = 1'b0;
  end
endmodule

// >>> tb/timer_event_counters_monitor.sv
// Port-level checker for the timer/event counters
`timescale 1ns/1ps
module timer_event_counters_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [2:0] timer_pin_i,
  input wire logic [2:0] irq_clear_i,
  input wire logic [2:0] irq_flag_o,
  input wire logic [2:0] irq_o
);
  logic [2:0] ie_reg;
  logic [2:0] keep_reg;
  logic c2_run_reg;
  // Shadow only ever errs toward running, since hardware may clear the run bit
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ie_reg <= 3'h0;
      c2_run_reg <= 1'b0;
    end else if (wr_en_i && addr_i == timer_event_counters_pkg::ADDR_INT_CTRL) begin
      ie_reg <= wr_data_i[2:0];
    end else if (wr_en_i && addr_i == timer_event_counters_pkg::ADDR_C2_CTRL) begin
      c2_run_reg <= wr_data_i[4];
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      keep_reg <= 3'h0;
    end else begin
      keep_reg <= irq_flag_o & ~irq_clear_i;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence low_read_twice;
    rd_en_i && !wr_en_i && addr_i == timer_event_counters_pkg::ADDR_C0_LOW
    ##1 rd_en_i && !wr_en_i && addr_i == timer_event_counters_pkg::ADDR_C0_LOW;
  endsequence
  sequence c2_stopped_load;
    wr_en_i && !c2_run_reg && addr_i == timer_event_counters_pkg::ADDR_C2_VALUE
    ##1 rd_en_i && !wr_en_i && addr_i == timer_event_counters_pkg::ADDR_C2_VALUE;
  endsequence
  a_reset_clean: assert property ($rose(rst_n_i) |-> rd_data_o == 8'h00 && irq_flag_o == 3'h0)
    else $error("outputs not clear after reset");
  a_unmapped_zero: assert property (rd_en_i && addr_i > 4'h8 |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!rd_en_i |=> $stable(rd_data_o))
    else $error("read data moved without a read");
  a_enable_read: assert property (rd_en_i && !wr_en_i && addr_i == 4'h8 |=> rd_data_o == {5'h00, ie_reg})
    else $error("interrupt enable readback wrong");
  a_irq_gating: assert property (irq_o == (irq_flag_o & ie_reg))
    else $error("interrupt not gated by enable");
  a_flag_sticky: assert property ((irq_flag_o & keep_reg) == keep_reg)
    else $error("flag dropped without clear");
  a_low_reread: assert property (low_read_twice |=> rd_data_o == $past(rd_data_o))
    else $error("low byte read not from buffer");
  a_stopped_load: assert property (c2_stopped_load |=> rd_data_o == $past(wr_data_i, 2))
    else $error("stopped preload not loaded");
endmodule
bind timer_event_counters timer_event_counters_monitor u_mon (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .timer_pin_i(timer_pin_i),
  .irq_clear_i(irq_clear_i), .irq_flag_o(irq_flag_o), .irq_o(irq_o));

// >>> tb/timer_event_counters_tb_top.sv
// Self-checking bench for the timer/event counters
`timescale 1ns/1ps
module timer_event_counters_tb_top;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic [7:0] rd_data_o, h, l, v;
  logic [7:0] width = 8'h02;
  logic [2:0] irq_clear_i = 3'h0;
  logic [2:0] irq_flag_o, irq_o;
  logic [3:0] npulse = 4'h1;
  logic pin, busy, start = 1'b0, idle = 1'b0;
  int num_errors = 0, n_checks = 0, n;
  row_t rows [6] = '{'{4'h2, 8'h8d, 8'h8d}, '{4'h5, 8'h48, 8'h48}, '{4'h7, 8'hc7, 8'hc7},
    '{4'h8, 8'hff, 8'h07}, '{4'hf, 8'haa, 8'h00}, '{4'h6, 8'h5a, 8'h5a}};
  timer_event_counters DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
    .timer_pin_i({3{pin}}), .irq_clear_i(irq_clear_i), .irq_flag_o(irq_flag_o), .irq_o(irq_o));
  pulse_source u_src (.clk_sys_i(clk_sys_i), .start_i(start), .idle_i(idle), .width_i(width),
    .count_i(npulse), .pin_o(pin), .busy_o(busy));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(logic [15:0] g, logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Both strobes are dropped here; wr and rd drop only the other one, so back-to-back accesses never reassign one in a step
  task automatic cyc(int k);
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    addr_i = a;
    wr_data_i = d;
    wr_en_i = 1'b1;
    rd_en_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    addr_i = a;
    rd_en_i = 1'b1;
    wr_en_i = 1'b0;
    @(posedge clk_sys_i);
    #1 d = rd_data_o;
  endtask
  task automatic pulse(logic [3:0] k, logic [7:0] w);
    npulse = k;
    width = w;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(1);
    for (n = 0; busy === 1'b1 && n < 3000; n++) cyc(1);
    chk(busy, 1'b0);
    cyc(2);
  endtask
  task automatic wait_flag(int b);
    for (n = 0; irq_flag_o[b] !== 1'b1 && n < 500; n++) cyc(1);
  endtask
  task automatic clr(logic [2:0] m);
    irq_clear_i = m;
    cyc(1);
    irq_clear_i = 3'h0;
  endtask
  task automatic ev(logic [3:0] a, logic [7:0] c, logic [3:0] k);
    wr(a, 8'h00);
    wr(a + 4'h1, 8'h00);
    wr(a + 4'h2, c);
    pulse(k, 8'h02);
    wr(a + 4'h2, c & 8'hef);
    rd(a + 4'h1, h);
    rd(a, l);
    chk({h, l}, {12'h000, k});
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    rd(timer_event_counters_pkg::ADDR_INT_CTRL, v);
    chk({v, 5'h00, irq_flag_o}, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // Low write must stay in the buffer until the high write
    wr(timer_event_counters_pkg::ADDR_C0_LOW, 8'h34);
    rd(timer_event_counters_pkg::ADDR_C0_HIGH, h);
    rd(timer_event_counters_pkg::ADDR_C0_LOW, l);
    chk({h, l}, 16'h0000);
    wr(timer_event_counters_pkg::ADDR_C0_LOW, 8'h34);
    wr(timer_event_counters_pkg::ADDR_C0_HIGH, 8'h12);
    rd(timer_event_counters_pkg::ADDR_C0_HIGH, h);
    rd(timer_event_counters_pkg::ADDR_C0_LOW, l);
    chk({h, l}, 16'h1234);
    wr(4'h8, 8'h04);
    wr(4'h6, 8'hf0);
    wr(4'h7, 8'h90);
    wait_flag(2);
    chk(n >= 15 && n <= 19, 1);
    chk(irq_o, 3'h4);
    wr(4'h8, 8'h00);
    chk({irq_o, irq_flag_o}, 6'h04);
    clr(3'h4);
    wr(4'h6, 8'hf8);
    wait_flag(2);
    chk(n >= 11 && n <= 17, 1);
    clr(3'h4);
    wait_flag(2);
    chk(n >= 5 && n <= 9, 1);
    wr(4'h7, 8'h80);
    wr(4'h0, 8'hf0);
    wr(4'h1, 8'hff);
    wr(4'h2, 8'h92);
    cyc(8);
    rd(4'h1, h);
    rd(4'h0, l);
    cyc(8);
    rd(4'h0, v);
    rd(4'h0, v);
    chk({h, l}, {8'hff, v});
    chk(l >= 8'hf1 && l <= 8'hf3, 1);
    wait_flag(0);
    chk(n >= 40 && n <= 50, 1);
    wr(4'h2, 8'h00);
    clr(3'h1);
    ev(timer_event_counters_pkg::ADDR_C1_LOW, 8'h50, 4'h5);
    idle = 1'b1;
    cyc(2);
    ev(timer_event_counters_pkg::ADDR_C0_LOW, 8'h5f, 4'h3);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'hd0);
    pulse(4'h1, 8'h0a);
    rd(4'h7, v);
    chk(v, 8'hc0);
    rd(4'h6, v);
    chk(v >= 8'h09 && v <= 8'h0b, 1);
    pulse(4'h1, 8'h0a);
    rd(4'h6, l);
    chk(l, v);
    wr(4'h7, 8'h10);
    cyc(8);
    rd(4'h6, l);
    chk(l, v);
    tally_and_finish();
  end
  initial begin
    #300us;
    num_errors++;
    tally_and_finish();
  end
endmodule
